// ==== inc/dtm_pkg.sv ====
// constants, register map and types for the die thermal monitor control block
package dtm_pkg;

    // clocking: system clock and the derived low-frequency timer tick
    localparam int CLK_HZ           = 20_000_000;  // system clock rate
    localparam int LF_HZ            = 100_000;     // low-frequency timer clock rate
    localparam int LF_DIV           = CLK_HZ / LF_HZ;

    // printed times, all in microseconds
    localparam int DB_TIME_US       = 10;          // comparator debounce, both directions
    localparam int WIN_TIME_US      = 450;         // sampling window
    localparam int INTERVAL_TIME_US = 3000;        // sampling interval (3.0 ms)

    // times as low-frequency ticks: least times round up, none below one tick
    localparam int DB_TICKS_RAW     = (DB_TIME_US * LF_HZ + 999_999) / 1_000_000;
    localparam int DB_TICKS         = (DB_TICKS_RAW < 1) ? 1 : DB_TICKS_RAW;
    localparam int WIN_TICKS        = (WIN_TIME_US * LF_HZ) / 1_000_000;
    localparam int INTERVAL_TICKS   = (INTERVAL_TIME_US * LF_HZ) / 1_000_000;

    // threshold count (80, 95, 110, 125, 140, 155 degrees)
    localparam int N_WARN           = 6;

    // axi4-lite geometry
    localparam int ADDR_W           = 8;
    localparam int DATA_W           = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;  // enable and always-on select
    localparam logic [ADDR_W-1:0] REG_FLAG  = 8'h04;  // sticky interrupt flags
    localparam logic [ADDR_W-1:0] REG_MASK  = 8'h08;  // interrupt masks, 1 = masked
    localparam logic [ADDR_W-1:0] REG_SENSE = 8'h0c;  // live sense and status, read only

    // control register fields
    localparam int CTRL_EN_BIT      = 0;   // monitor_enable_bit
    localparam int CTRL_AON_BIT     = 1;   // monitor_always_on_select

    // sense register fields
    localparam int SENSE_ANY_BIT    = 6;   // warn_sense_flag_any
    localparam int SENSE_SD_BIT     = 7;   // thermal shutdown in force
    localparam int SENSE_PWR_BIT    = 8;   // monitor powered now

    // reset values
    localparam logic [1:0]        CTRL_RST  = 2'h0;
    localparam logic [N_WARN-1:0] MASK_RST  = 6'h3f;
    localparam logic [N_WARN-1:0] FLAG_RST  = 6'h00;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register select
    typedef enum logic [2:0] {
        SEL_CTRL  = 3'b000,
        SEL_FLAG  = 3'b001,
        SEL_MASK  = 3'b010,
        SEL_SENSE = 3'b011,
        SEL_NONE  = 3'b100
    } dtm_sel_t;

    // monitor power mode
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_AON    = 2'b01,
        MODE_SAMPLE = 2'b10
    } dtm_mode_t;

endpackage

// ==== logic/dtm_debounce.sv ====
// bidirectional tick-based debouncer for a group of comparator outputs
`timescale 1ns/1ps

module dtm_debounce
    import dtm_pkg::*;
#(
    parameter int W        = 7,
    parameter int DB_COUNT = DB_TICKS
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // control
    input  wire logic         en,      // monitor powered, comparators valid
    input  wire logic         tick,    // low-frequency timer tick
    // comparators and results
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] state,   // debounced level
    output logic      [W-1:0] rise     // one-cycle pulse on debounced rise
);

    localparam int CW = $clog2(DB_COUNT + 1);
    localparam logic [CW-1:0] DB_LAST = CW'(DB_COUNT - 1);

    logic [W-1:0]  state_q, state_d;   // debounced levels
    logic [W-1:0]  rise_q,  rise_d;    // rising-edge pulses
    logic [CW-1:0] cnt_q [W];          // per-bit stability counters
    logic [CW-1:0] cnt_d [W];

    // count ticks while a bit differs; flip once it stayed different long enough
    always_comb begin
        state_d = state_q;
        for (int i = 0; i < W; i++) begin
            cnt_d[i] = cnt_q[i];
            if (!en || raw[i] == state_q[i]) begin
                // disabled or agreeing: no pending change
                cnt_d[i] = '0;
            end else if (tick) begin
                if (cnt_q[i] == DB_LAST) begin
                    state_d[i] = raw[i];
                    cnt_d[i]   = '0;
                end else begin
                    cnt_d[i] = cnt_q[i] + CW'(1);
                end
            end
        end
        rise_d = state_d & ~state_q;
    end

    // register debouncer state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= '0;
            rise_q  <= '0;
            for (int i = 0; i < W; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            state_q <= state_d;
            rise_q  <= rise_d;
            for (int i = 0; i < W; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    assign state = state_q;
    assign rise  = rise_q;

    // a debounced level moves only on a tick while enabled
    property p_db_on_tick;
        @(posedge clk) disable iff (!rst_b)
        (state_q != $past(state_q)) |-> ($past(tick) && $past(en));
    endproperty
    a_db_on_tick: assert property (p_db_on_tick) else $error("debounced level moved off a tick");

    // nothing moves while the monitor is unpowered
    property p_db_hold;
        @(posedge clk) disable iff (!rst_b)
        !en |=> (state_q == $past(state_q)) && (rise_q == '0);
    endproperty
    a_db_hold: assert property (p_db_hold) else $error("debounced level changed while disabled");

endmodule

// ==== logic/dtm_ctrl.sv ====
// die thermal monitor control: debounce, flags, sampling, shutdown and axi4-lite registers
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module dtm_ctrl
    import dtm_pkg::*;
#(
    parameter int DIV_COUNT  = LF_DIV,          // system clocks per low-frequency tick
    parameter int DB_COUNT   = DB_TICKS,        // debounce length in ticks
    parameter int WIN_COUNT  = WIN_TICKS,       // sampling window in ticks
    parameter int INT_COUNT  = INTERVAL_TICKS   // sampling interval in ticks
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // centre-die sensor comparators and system state
    input  wire logic [N_WARN-1:0] warn_cmp_in,        // warning comparators, analog hysteresis inside
    input  wire logic              shutdown_cmp_in,    // shutdown comparator, analog hysteresis inside
    input  wire logic              standby_state,      // 1 = standby, 0 = run
    // outputs to the system
    output logic                   monitor_power_en,   // powers the sensor and comparators
    output logic                   thermal_shutdown,   // level: shutdown in force, restart blocked
    output logic                   shared_irq_out_n    // active-low shared interrupt
);

    localparam int DW = $clog2(DIV_COUNT);
    localparam int SW = $clog2(INT_COUNT);
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV_COUNT - 1);
    localparam logic [SW-1:0] INT_LAST = SW'(INT_COUNT - 1);
    localparam logic [SW-1:0] WIN_END  = SW'(WIN_COUNT);

    // map a byte address to a register select; unaligned or unknown is none
    function automatic dtm_sel_t dtm_decode(input logic [ADDR_W-1:0] a);
        unique case (a)
            REG_CTRL:  dtm_decode = SEL_CTRL;
            REG_FLAG:  dtm_decode = SEL_FLAG;
            REG_MASK:  dtm_decode = SEL_MASK;
            REG_SENSE: dtm_decode = SEL_SENSE;
            default:   dtm_decode = SEL_NONE;
        endcase
    endfunction

    // timer state
    logic [DW-1:0]     div_q, div_d;        // system clock divider
    logic              tick;                // one-cycle low-frequency tick
    logic [SW-1:0]     slot_q, slot_d;      // position in the sampling interval
    dtm_mode_t         mode;                // present power mode
    logic              power_q, power_d;    // monitor power
    // software state
    logic [1:0]        ctrl_q, ctrl_d;      // enable and always-on select
    logic [N_WARN-1:0] flag_q, flag_d;      // sticky interrupt flags
    logic [N_WARN-1:0] mask_q, mask_d;      // interrupt masks
    logic [N_WARN-1:0] flag_clr;            // flags cleared this cycle
    logic              sd_q, sd_d;          // shutdown in force
    // debounced comparators
    logic [N_WARN:0]   db_state;            // [N_WARN] is the shutdown comparator
    logic [N_WARN:0]   db_rise;             // debounced rising edges
    logic [N_WARN-1:0] sense;               // live sense flags
    // axi write side
    logic              aw_got_q, aw_got_d;  // write address held
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic              w_got_q, w_got_d;    // write data held
    logic [DATA_W-1:0] w_data_q, w_data_d;
    logic [3:0]        w_strb_q, w_strb_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              do_write;            // both halves present
    dtm_sel_t          wsel;
    // axi read side
    logic              rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic              rd_take;             // read address accepted
    dtm_sel_t          rsel;

    // low-frequency tick and sampling slot counter
    always_comb begin
        tick   = (div_q == DIV_LAST);
        div_d  = tick ? '0 : div_q + DW'(1);
        slot_d = slot_q;
        if (mode != MODE_SAMPLE) begin
            // restart so that sampling opens with a window
            slot_d = '0;
        end else if (tick) begin
            slot_d = (slot_q == INT_LAST) ? '0 : slot_q + SW'(1);
        end
    end

    // power mode from enable, always-on select and run or standby
    always_comb begin
        if (!ctrl_q[CTRL_EN_BIT]) begin
            mode = MODE_OFF;
        end else if (ctrl_q[CTRL_AON_BIT] && !standby_state) begin
            mode = MODE_AON;
        end else begin
            mode = MODE_SAMPLE;
        end
        unique case (mode)
            MODE_OFF:    power_d = 1'b0;
            MODE_AON:    power_d = 1'b1;
            MODE_SAMPLE: power_d = (slot_q < WIN_END);
            default:     power_d = 1'b0;
        endcase
    end

    // register timers and power
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_q   <= '0;
            slot_q  <= '0;
            power_q <= 1'b0;
        end else begin
            div_q   <= div_d;
            slot_q  <= slot_d;
            power_q <= power_d;
        end
    end

    // only the centre-die comparators enter; held while unpowered
    dtm_debounce #(
        .W        (N_WARN + 1),
        .DB_COUNT (DB_COUNT)
    ) u_debounce (
        .clk   (clk),
        .rst_b (rst_b),
        .en    (power_q),
        .tick  (tick),
        .raw   ({shutdown_cmp_in, warn_cmp_in}),
        .state (db_state),
        .rise  (db_rise)
    );

    // sense follows the debounced comparator, whose hysteresis sets release
    assign sense = db_state[N_WARN-1:0];

    // axi write channel acceptance and response
    always_comb begin
        s_axi_awready = !aw_got_q && !bvalid_q;
        s_axi_wready  = !w_got_q && !bvalid_q;
        do_write      = aw_got_q && w_got_q && !bvalid_q;
        wsel          = dtm_decode(aw_addr_q);
        aw_got_d      = aw_got_q;
        aw_addr_d     = aw_addr_q;
        w_got_d       = w_got_q;
        w_data_d      = w_data_q;
        w_strb_d      = w_strb_q;
        bvalid_d      = bvalid_q;
        bresp_d       = bresp_q;
        // capture either half in any order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d  = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d  = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        // commit and answer
        if (do_write) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // axi read channel: data registered one cycle after address
    always_comb begin
        s_axi_arready = !rvalid_q;
        rd_take       = s_axi_arvalid && s_axi_arready;
        rsel          = dtm_decode(s_axi_araddr);
        rvalid_d      = rvalid_q;
        rdata_d       = rdata_q;
        rresp_d       = rresp_q;
        if (rd_take) begin
            rvalid_d = 1'b1;
            rresp_d  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            rdata_d  = '0;
            unique case (rsel)
                SEL_CTRL:  rdata_d[1:0]        = ctrl_q;
                SEL_FLAG:  rdata_d[N_WARN-1:0] = flag_q;
                SEL_MASK:  rdata_d[N_WARN-1:0] = mask_q;
                SEL_SENSE: begin
                    rdata_d[N_WARN-1:0]   = sense;
                    rdata_d[SENSE_ANY_BIT] = |sense;
                    rdata_d[SENSE_SD_BIT]  = sd_q;
                    rdata_d[SENSE_PWR_BIT] = power_q;
                end
                SEL_NONE:  rdata_d = '0;
                default:   rdata_d = '0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // software registers, sticky flags and shutdown latch
    always_comb begin
        ctrl_d   = ctrl_q;
        mask_d   = mask_q;
        flag_clr = '0;
        if (do_write && w_strb_q[0]) begin
            unique case (wsel)
                SEL_CTRL: ctrl_d   = w_data_q[1:0];
                SEL_MASK: mask_d   = w_data_q[N_WARN-1:0];
                SEL_FLAG: flag_clr = w_data_q[N_WARN-1:0];
                default:  ctrl_d   = ctrl_q;
            endcase
        end
        // a read of the flag register clears what it returned
        if (rd_take && rsel == SEL_FLAG) begin
            flag_clr = flag_clr | flag_q;
        end
        // a new crossing wins over a clear in the same cycle
        flag_d = (flag_q & ~flag_clr) | db_rise[N_WARN-1:0];
        // shutdown holds until the debounced comparator has released
        if (db_rise[N_WARN]) begin
            sd_d = 1'b1;
        end else if (!db_state[N_WARN]) begin
            sd_d = 1'b0;
        end else begin
            sd_d = sd_q;
        end
    end

    // register bus and software state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= '0;
            w_got_q   <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
            ctrl_q    <= CTRL_RST;
            mask_q    <= MASK_RST;
            flag_q    <= FLAG_RST;
            sd_q      <= 1'b0;
        end else begin
            aw_got_q  <= aw_got_d;
            aw_addr_q <= aw_addr_d;
            w_got_q   <= w_got_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            ctrl_q    <= ctrl_d;
            mask_q    <= mask_d;
            flag_q    <= flag_d;
            sd_q      <= sd_d;
        end
    end

    // outputs
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign monitor_power_en = power_q;
    assign thermal_shutdown = sd_q;
    assign shared_irq_out_n = !(|(flag_q & ~mask_q));

    // interrupt output tracks the unmasked flags a cycle after a crossing
    property p_irq_follow;
        @(posedge clk) disable iff (!rst_b)
        ((|(db_rise[N_WARN-1:0] & ~mask_q)) && (mask_d == mask_q)) |=> !shared_irq_out_n;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("unmasked crossing did not raise interrupt");

    // a debounced crossing lands in its flag
    property p_flag_set;
        @(posedge clk) disable iff (!rst_b)
        (db_rise[N_WARN-1:0] != '0) |=> ((flag_q & $past(db_rise[N_WARN-1:0])) == $past(db_rise[N_WARN-1:0]));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("crossing did not set its flag");

    // a flag only falls after a clear
    property p_flag_sticky;
        @(posedge clk) disable iff (!rst_b)
        (|($past(flag_q) & ~flag_q)) |-> ($past(flag_clr) != '0);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without a clear");

    // disabled monitor stays unpowered
    property p_off;
        @(posedge clk) disable iff (!rst_b)
        !ctrl_q[CTRL_EN_BIT] |=> !power_q;
    endproperty
    a_off: assert property (p_off) else $error("monitor powered while disabled");

    // always-on in run keeps power up
    property p_aon;
        @(posedge clk) disable iff (!rst_b)
        (ctrl_q[CTRL_EN_BIT] && ctrl_q[CTRL_AON_BIT] && !standby_state) [*2] |-> power_q;
    endproperty
    a_aon: assert property (p_aon) else $error("always-on run mode lost power");

    // in sampling the power is on exactly inside the window slots
    property p_window;
        @(posedge clk) disable iff (!rst_b)
        ($past(mode) == MODE_SAMPLE) |-> (power_q == ($past(slot_q) < WIN_END));
    endproperty
    a_window: assert property (p_window) else $error("sampling power outside its window");

    // standby powers the monitor only inside the sampling window
    property p_standby;
        @(posedge clk) disable iff (!rst_b)
        (standby_state && ctrl_q[CTRL_EN_BIT]) |=> (power_q == ($past(slot_q) < WIN_END));
    endproperty
    a_standby: assert property (p_standby) else $error("standby left sampling mode");

    // shutdown rises with the debounced trip and holds while it stays
    property p_shutdown;
        @(posedge clk) disable iff (!rst_b)
        db_rise[N_WARN] |=> sd_q ##1 (sd_q || !db_state[N_WARN]);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown did not follow trip");

endmodule

// ==== sim/dtm_host_model.sv ====
// host-side axi4-lite master model for the thermal monitor registers
`timescale 1ns/1ps
module dtm_host_model
    import dtm_pkg::*;
(
    // clock
    input  wire logic              clk,
    // write channels
    output logic [ADDR_W-1:0]      s_axi_awaddr,
    output logic                   s_axi_awvalid,
    input  wire logic              s_axi_awready,
    output logic [DATA_W-1:0]      s_axi_wdata,
    output logic [3:0]             s_axi_wstrb,
    output logic                   s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_bvalid,
    output logic                   s_axi_bready,
    // read channels
    output logic [ADDR_W-1:0]      s_axi_araddr,
    output logic                   s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [DATA_W-1:0] s_axi_rdata,
    input  wire logic [1:0]        s_axi_rresp,
    input  wire logic              s_axi_rvalid,
    output logic                   s_axi_rready
);
    // idle bus from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    end
    // write one word; readies sampled at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        s_axi_bready <= 1'b0;
    endtask
    // read one word, rready held until rvalid
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) break;
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ==== sim/dtm_ctrl_tb.sv ====
// self-checking testbench for the die thermal monitor control block
`timescale 1ns/1ps
module dtm_ctrl_tb;
    import dtm_pkg::*;
    // bench signals, named as the ports
    logic clk, rst_b, standby_state, shutdown_cmp_in;
    logic [N_WARN-1:0] warn_cmp_in;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic monitor_power_en, thermal_shutdown, shared_irq_out_n;
    int   bad_count = 0;
    int   n_checks  = 0;
    logic [1:0] br;
    // short timer counts: tick 4 clocks, window 3 ticks, interval 8 ticks
    dtm_ctrl #(.DIV_COUNT(4), .DB_COUNT(1), .WIN_COUNT(3), .INT_COUNT(8)) DUT (.clk, .rst_b,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .warn_cmp_in,
        .shutdown_cmp_in, .standby_state, .monitor_power_en, .thermal_shutdown, .shared_irq_out_n);
    dtm_host_model host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    // clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // compare one value
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read a register, compare data and response
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] re);
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, re});
    endtask
    // let n falling edges pass, outputs settled
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // count powered cycles over two sampling intervals
    task automatic cnt_pwr(output logic [DATA_W-1:0] n);
        n = '0;
        wt(2);
        repeat (64) begin
            @(negedge clk);
            n = n + monitor_power_en;
        end
    endtask
    // reset values, unmapped address
    task automatic t_reset;
        rchk(REG_CTRL, 32'h0, RESP_OKAY);
        rchk(REG_MASK, 32'h3f, RESP_OKAY);
        rchk(REG_FLAG, 32'h0, RESP_OKAY);
        rchk(8'h10, 32'h0, RESP_SLVERR);
        host.wr(8'h10, 32'h3, br);
        chk({30'h0, br}, {30'h0, RESP_SLVERR});
        rchk(REG_CTRL, 32'h0, RESP_OKAY);
        wt(1);
        chk(shared_irq_out_n, 1'b1);
        chk(monitor_power_en, 1'b0);
    endtask
    // comparators ignored while disabled
    task automatic t_off;
        @(posedge clk) warn_cmp_in <= 6'h3f;
        wt(20);
        rchk(REG_FLAG, 32'h0, RESP_OKAY);
        @(posedge clk) warn_cmp_in <= 6'h00;
    endtask
    // always-on: flag, sense, mask and clear
    task automatic t_aon;
        host.wr(REG_CTRL, 32'h3, br);
        chk({30'h0, br}, {30'h0, RESP_OKAY});
        wt(2);
        chk(monitor_power_en, 1'b1);
        host.wr(REG_MASK, 32'h3e, br);
        @(posedge clk) warn_cmp_in <= 6'h01;
        wt(10);
        chk(shared_irq_out_n, 1'b0);
        rchk(REG_SENSE, 32'h141, RESP_OKAY);
        host.wr(REG_FLAG, 32'h1, br);
        wt(2);
        chk(shared_irq_out_n, 1'b1);
        @(posedge clk) warn_cmp_in <= 6'h00;
        wt(10);
        rchk(REG_SENSE, 32'h100, RESP_OKAY);
        @(posedge clk) warn_cmp_in <= 6'h3f;
        wt(10);
        host.wr(REG_FLAG, 32'h1, br);
        wt(2);
        chk(shared_irq_out_n, 1'b1);
        rchk(REG_FLAG, 32'h3e, RESP_OKAY);
        rchk(REG_FLAG, 32'h0, RESP_OKAY);
        @(posedge clk) warn_cmp_in <= 6'h00;
    endtask
    // shutdown trip and release
    task automatic t_sd;
        @(posedge clk) shutdown_cmp_in <= 1'b1;
        wt(10);
        chk(thermal_shutdown, 1'b1);
        rchk(REG_SENSE, 32'h180, RESP_OKAY);
        @(posedge clk) shutdown_cmp_in <= 1'b0;
        wt(10);
        chk(thermal_shutdown, 1'b0);
    endtask
    // sampling duty in run and standby, then disable
    task automatic t_samp;
        logic [DATA_W-1:0] n;
        host.wr(REG_CTRL, 32'h1, br);
        cnt_pwr(n);
        chk(n, 32'd24);
        host.wr(REG_CTRL, 32'h3, br);
        @(posedge clk) standby_state <= 1'b1;
        cnt_pwr(n);
        chk(n, 32'd24);
        host.wr(REG_CTRL, 32'h0, br);
        wt(4);
        chk(monitor_power_en, 1'b0);
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #(50 * 20000);
        bad_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rst_b = 1'b0;
        warn_cmp_in = '0;
        shutdown_cmp_in = 1'b0;
        standby_state = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_off();
        t_aon();
        t_sd();
        t_samp();
        tally_and_finish();
    end
endmodule
